/* File: bench/rmtdc_card_model.sv */
// Card and carrier model that feeds the receiver and driver inputs
`timescale 1ns/1ns
module rmtdc_card_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Stream request from the bench
  input wire logic streamReq,
  input wire logic [7:0] reqBits,
  input wire logic [7:0] reqErr,
  // Carrier and receiver side
  output logic carrierIn,
  output logic rxStreamEnd,
  output logic [7:0] rxBitCount,
  output logic [7:0] errorFlags
);
  // Carrier sample runs free and toggles every cycle
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      carrierIn <= 1'h0;
    end else begin
      carrierIn <= ~carrierIn;
    end
  end
  // One-cycle stream end; count and error byte scramble outside it
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rxStreamEnd <= 1'h0;
      rxBitCount <= 8'h00;
      errorFlags <= 8'h00;
    end else if (streamReq) begin
      rxStreamEnd <= 1'h1;
      rxBitCount <= reqBits;
      errorFlags <= reqErr;
    end else begin
      rxStreamEnd <= 1'h0;
      rxBitCount <= ~rxBitCount;
      errorFlags <= errorFlags + 8'h35;
    end
  end
endmodule : rmtdc_card_model

/* File: bench/rx_mode_tx_driver_control_tb.sv */
// Self-checking testbench for the receive mode and antenna driver block
`timescale 1ns/1ns
`define CHK(nm, ex, ac) begin comparisons++; if ((ex) !== (ac)) begin err_total++; \
  $display("mismatch %s expected %h seen %h", nm, ex, ac); end end
module rx_mode_tx_driver_control_tb;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clock = 1'h0;
  logic rst_n = 1'h0;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic cmdWrite = 1'h0, rxStart = 1'h0, rfComm = 1'h0, txModulate = 1'h0;
  logic [3:0] cmdCode = 4'h0;
  logic streamReq = 1'h0;
  logic [7:0] reqBits = 8'h00, reqErr = 8'h00;
  logic [31:0] prdata, rd;
  logic pready, pslverr, rxActive, crcCheckEnable, crcPresetFromMode, fifoWrite;
  logic [2:0] rxRate;
  logic [1:0] receive_frame_format;
  logic [7:0] fifoData, rxBitCount, errorFlags, m, ctl;
  logic antennaDriverA, antennaDriverB, reducedDepth, fullDepthAsk, carrierIn, rxStreamEnd;
  logic er, car, md, rf, frc;
  logic [31:0] seed = 32'h0000_c66b;
  logic [31:0] r;
  int err_total = 0;
  int comparisons = 0;
  int cycles = 0;
  // Clock generator
  always #5 clock = ~clock;
  rmtdc_top uut (.clock, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .cmdWrite, .cmdCode, .rxStart, .rfComm, .rxStreamEnd, .rxBitCount,
    .errorFlags, .rxActive, .crcCheckEnable, .rxRate, .receive_frame_format, .crcPresetFromMode,
    .fifoWrite, .fifoData, .carrierIn, .txModulate, .antennaDriverA, .antennaDriverB,
    .reducedDepth, .fullDepthAsk);
  rmtdc_card_model card (.clock, .rst_n, .streamReq, .reqBits, .reqErr, .carrierIn,
    .rxStreamEnd, .rxBitCount, .errorFlags);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Fixed-seed shift register, stepped a byte at a time
  function automatic logic [31:0] rnd();
    repeat (8) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd
  // Expected pin level from control byte, force bit, carrier and envelope
  function automatic logic drv_exp(input logic [7:0] c, input logic f, car, md, b);
    logic en;
    logic inv;
    en = b ? c[1] : c[0];
    inv = en ? (b ? c[7] : c[6]) : (b ? c[5] : c[4]);
    return (en & car & ((b & c[3]) | ~(md & f))) ^ inv;
  endfunction : drv_exp
  // Prints the counts and the verdict, then stops
  task automatic finish_test();
    $display("comparisons %0d errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test
  // One APB transfer; holds the request until pready is seen
  task automatic apb(input logic w, input logic [7:0] a, d, output logic [31:0] q,
                     output logic e);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {seed[31:8], d};
    @(posedge clock);
    penable <= 1'h1;
    do begin
      @(posedge clock);
    end while (pready !== 1'h1);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clock);
  endtask : apb
  task automatic wr(input logic [7:0] a, d);
    apb(1'h1, a, d, rd, er);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, ex);
    apb(1'h0, a, 8'h00, rd, er);
    `CHK("rdata", {24'h00_0000, ex}, rd)
    `CHK("slverr", 1'h0, er)
  endtask : rd_chk
  // Receiver start or command write, then receiver state check
  task automatic evt(input logic st, input logic [3:0] c, input logic act);
    rxStart <= st;
    cmdWrite <= ~st;
    cmdCode <= c;
    @(posedge clock);
    rxStart <= 1'h0;
    cmdWrite <= 1'h0;
    #1 `CHK("rxActive", act, rxActive)
    @(posedge clock);
  endtask : evt
  // Stream end from the card, then receiver and error byte check
  task automatic send(input logic [7:0] bits, input logic act, fw);
    r = rnd();
    streamReq <= 1'h1;
    reqBits <= bits;
    reqErr <= r[7:0];
    @(posedge clock);
    streamReq <= 1'h0;
    @(posedge clock);
    #1 `CHK("rxActive", act, rxActive)
    `CHK("fifoWrite", fw, fifoWrite)
    if (fw) `CHK("fifoData", r[7:0], fifoData)
    @(posedge clock);
  endtask : send
  // Hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      finish_test();
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge clock);
    rst_n <= 1'h1;
    #1 `CHK("pinA", 1'h0, antennaDriverA)
    `CHK("pinB", 1'h0, antennaDriverB)
    @(posedge clock);
    rd_chk(rmtdc_pkg::RX_MODE_ADDR, 8'h00);
    rd_chk(rmtdc_pkg::DRV_CTL_ADDR, 8'h80);
    rd_chk(rmtdc_pkg::TX_MOD_ADDR, 8'h00);
    for (int i = 0; i < 12; i++) begin
      r = rnd();
      m = {r[7], i[2:0], r[3:2], i[1:0]};
      if (m[6:4] != 3'h0) m[7] = 1'h1;
      if (m[6:4] == 3'h0) m[2] = 1'h0;
      ctl = (i < 2) ? {8{i[0]}} : r[15:8];
      frc = r[22];
      wr(rmtdc_pkg::RX_MODE_ADDR, m);
      wr(rmtdc_pkg::DRV_CTL_ADDR, ctl);
      wr(rmtdc_pkg::TX_MOD_ADDR, r[23:16]);
      rd_chk(rmtdc_pkg::RX_MODE_ADDR, m);
      rd_chk(rmtdc_pkg::DRV_CTL_ADDR, ctl & 8'hFB);
      rd_chk(rmtdc_pkg::TX_MOD_ADDR, r[23:16] & 8'h40);
      `CHK("crcEn", m[7], crcCheckEnable)
      `CHK("rxRate", m[6:4], rxRate)
      `CHK("receive_frame_format", m[1:0], receive_frame_format)
      `CHK("fullAsk", frc, fullDepthAsk)
      for (int k = 0; k < 6; k++) begin
        @(posedge clock);
        car = carrierIn;
        md = txModulate;
        rf = rfComm;
        r = rnd();
        txModulate <= r[0];
        rfComm <= r[1];
        #1 `CHK("pinA", drv_exp(ctl, frc, car, md, 1'h0), antennaDriverA)
        `CHK("pinB", drv_exp(ctl, frc, car, md, 1'h1), antennaDriverB)
        `CHK("reduced", md & ~frc, reducedDepth)
        `CHK("preset", rf, crcPresetFromMode)
      end
      @(posedge clock);
    end
    apb(1'h0, 8'h58, 8'h00, rd, er);
    `CHK("unmapped", 32'h0000_0000, rd)
    `CHK("slverr", 1'h1, er)
    wr(rmtdc_pkg::RX_MODE_ADDR, 8'h00);
    evt(1'h1, 4'h0, 1'h1);
    send(8'h08, 1'h0, 1'h0);
    send(8'h08, 1'h0, 1'h0);
    wr(rmtdc_pkg::RX_MODE_ADDR, 8'h08);
    evt(1'h1, 4'h0, 1'h1);
    send(8'h03, 1'h1, 1'h0);
    send(8'h04, 1'h0, 1'h0);
    wr(rmtdc_pkg::RX_MODE_ADDR, 8'h94);
    evt(1'h1, 4'h0, 1'h1);
    send(8'h08, 1'h1, 1'h1);
    evt(1'h0, 4'h8, 1'h1);
    send(8'h05, 1'h1, 1'h1);
    evt(1'h0, 4'h3, 1'h0);
    evt(1'h1, 4'h0, 1'h1);
    wr(rmtdc_pkg::RX_MODE_ADDR, 8'h9C);
    send(8'h02, 1'h1, 1'h0);
    wr(rmtdc_pkg::RX_MODE_ADDR, 8'h90);
    send(8'h08, 1'h0, 1'h0);
    finish_test();
  end
endmodule : rx_mode_tx_driver_control_tb

/* File: src/rmtdc_driver.sv */
// Antenna driver output stage for the two driver pins
`timescale 1ns/1ns
module rmtdc_driver (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Carrier and transmit envelope
  input wire logic carrierIn,
  input wire logic txModulate,
  // Control bits
  input wire logic [7:0] drvCtl,
  input wire logic forceFull,
  // Driver pins and conductance select
  output logic antennaDriverA,
  output logic antennaDriverB,
  output logic reducedDepth
);

  // Enables and modulated carriers
  logic enA;
  logic enB;
  logic modCarrier;
  logic rawA;
  logic rawB;

  assign enA = drvCtl[rmtdc_pkg::DRV_A_EN_BIT];
  assign enB = drvCtl[rmtdc_pkg::DRV_B_EN_BIT];

  // Full depth gates the carrier off while modulating; else the carrier stays
  assign modCarrier = carrierIn & ~(txModulate & forceFull); // RL17
  assign rawA = modCarrier; // RL16
  assign rawB = drvCtl[rmtdc_pkg::DRV_B_CW_BIT] ? carrierIn : modCarrier; // RL14 RL15

  // Pin levels: inversion per enabled or disabled state
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      antennaDriverA <= 1'b0;
      antennaDriverB <= 1'b0;
    end else begin
      antennaDriverA <= enA ? (rawA ^ drvCtl[rmtdc_pkg::DRV_A_INV_ON_BIT]) // RL11
                            : drvCtl[rmtdc_pkg::DRV_A_INV_OFF_BIT]; // RL13
      antennaDriverB <= enB ? (rawB ^ drvCtl[rmtdc_pkg::DRV_B_INV_ON_BIT]) // RL10
                            : drvCtl[rmtdc_pkg::DRV_B_INV_OFF_BIT]; // RL12
    end
  end

  // Reduced conductance is used while modulating without forced full depth
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      reducedDepth <= 1'b0;
    end else begin
      reducedDepth <= txModulate & ~forceFull; // RL17
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_drv_b_cw: assert property (@(posedge clock) disable iff (!rst_n) // RL14
    enB && drvCtl[rmtdc_pkg::DRV_B_CW_BIT]
    |=> antennaDriverB == ($past(carrierIn) ^ $past(drvCtl[rmtdc_pkg::DRV_B_INV_ON_BIT])))
    else $error("driver B not carrying continuous carrier");
  a_drv_a_off: assert property (@(posedge clock) disable iff (!rst_n) // RL13
    !enA |=> antennaDriverA == $past(drvCtl[rmtdc_pkg::DRV_A_INV_OFF_BIT]))
    else $error("disabled driver A level wrong");
  a_full_depth: assert property (@(posedge clock) disable iff (!rst_n) // RL17
    forceFull && txModulate && enA && !drvCtl[rmtdc_pkg::DRV_A_INV_ON_BIT]
    |=> !antennaDriverA && !reducedDepth)
    else $error("forced full depth did not silence driver A");

endmodule : rmtdc_driver

/* File: src/rmtdc_pkg.sv */
// Shared constants for the receive mode and antenna driver control block
package rmtdc_pkg;

  // ----------------------------------------------------------------
  // Register indices and APB byte addresses (index times four)
  // ----------------------------------------------------------------
  localparam logic [7:0] RX_MODE_IDX = 8'h13; // Receive mode register index
  localparam logic [7:0] DRV_CTL_IDX = 8'h14; // Antenna driver control index
  localparam logic [7:0] TX_MOD_IDX = 8'h15; // Transmit modulation index
  localparam logic [7:0] RX_MODE_ADDR = 8'(RX_MODE_IDX * 4);
  localparam logic [7:0] DRV_CTL_ADDR = 8'(DRV_CTL_IDX * 4);
  localparam logic [7:0] TX_MOD_ADDR = 8'(TX_MOD_IDX * 4);

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int RX_CRC_EN_BIT = 7; // Receive CRC enable
  localparam int RX_SPEED_LSB = 4; // Receive bit rate, three bits
  localparam int RX_NOERR_BIT = 3; // Ignore invalid frame
  localparam int RX_MULTI_BIT = 2; // Multiple frame receive
  localparam int RX_FRAME_LSB = 0; // Receive frame format, two bits
  localparam int DRV_B_INV_ON_BIT = 7;
  localparam int DRV_A_INV_ON_BIT = 6;
  localparam int DRV_B_INV_OFF_BIT = 5;
  localparam int DRV_A_INV_OFF_BIT = 4;
  localparam int DRV_B_CW_BIT = 3;
  localparam int DRV_B_EN_BIT = 1;
  localparam int DRV_A_EN_BIT = 0;
  localparam int FORCE_FULL_BIT = 6;

  // ----------------------------------------------------------------
  // Reset values and writable bit masks
  // ----------------------------------------------------------------
  localparam logic [7:0] RX_MODE_RESET = 8'h00;
  localparam logic [7:0] DRV_CTL_RESET = 8'h80;
  localparam logic [7:0] TX_MOD_RESET = 8'h00;
  localparam logic [7:0] RX_MODE_MASK = 8'hFF;
  localparam logic [7:0] DRV_CTL_MASK = 8'hFB;
  localparam logic [7:0] TX_MOD_MASK = 8'h40;

  // ----------------------------------------------------------------
  // Receive path constants
  // ----------------------------------------------------------------
  localparam logic [7:0] MIN_STREAM_BITS = 8'h04; // Shorter streams are invalid
  localparam logic [3:0] CMD_RECEIVE_CODE = 4'h8; // Command engine code for receive

  // Receive bit rate codes
  typedef enum logic [2:0] {
    RATE_106 = 3'b000,
    RATE_212 = 3'b001,
    RATE_424 = 3'b010,
    RATE_848 = 3'b011
  } rmtdc_rate_e;

  // Receive frame format codes
  typedef enum logic [1:0] {
    FRAME_TYPE_A = 2'b00,
    FRAME_TYPE_B = 2'b11
  } rmtdc_frame_e;

endpackage : rmtdc_pkg

/* File: src/rmtdc_top.sv */
// Receive mode and antenna driver control registers with APB access
//
// How it works
// RL1 - CRC checked on receive when enabled
// RL2 - Software clears CRC enable only at 106
// RL3 - Speed field selects 106 to 848 rate
// RL4 - Short streams ignored, receiver stays active, while the ignore invalid frame bit is set
// RL5 - Single frame mode stops receiver after frame
// RL6 - Software uses multiple frames above 106 only
// RL7 - Multiple mode ends by command or clear
// RL8 - Multiple mode appends error byte per stream
// RL9 - Framing field selects type A or B
// RL10 - Invert driver B while enabled
// RL11 - Invert driver A while enabled
// RL12 - Invert driver B while disabled
// RL13 - Invert driver A while disabled
// RL14 - Driver B continuous carrier option
// RL15 - Driver B enable sends modulated carrier
// RL16 - Driver A enable sends modulated carrier
// RL17 - Forced full depth ASK modulation
// RL18 - Driver control resets to 80h
// RL19 - RF traffic uses mode-derived CRC preset
// RL20 - Reserved bits ignore writes, read zero
`timescale 1ns/1ns
module rmtdc_top (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Command engine
  input wire logic cmdWrite,
  input wire logic [3:0] cmdCode,
  input wire logic rxStart,
  input wire logic rfComm,
  // Receiver stream events
  input wire logic rxStreamEnd,
  input wire logic [7:0] rxBitCount,
  input wire logic [7:0] errorFlags,
  // Receiver controls
  output logic rxActive,
  output logic crcCheckEnable,
  output logic [2:0] rxRate,
  output logic [1:0] receive_frame_format,
  output logic crcPresetFromMode,
  // FIFO error byte append
  output logic fifoWrite,
  output logic [7:0] fifoData,
  // Analog front end
  input wire logic carrierIn,
  input wire logic txModulate,
  output logic antennaDriverA,
  output logic antennaDriverB,
  output logic reducedDepth,
  output logic fullDepthAsk
);

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [7:0] rxMode; // Receive mode
  logic [7:0] drvCtl; // Antenna driver control
  logic [7:0] txMod; // Transmit modulation

  // Bus decode
  logic access; // Access phase edge that completes a transfer
  logic wrEn; // Write completes this edge
  logic mapped; // Address hits a register
  logic [7:0] rdByte; // Read mux

  // Receive decode
  logic multiMode;
  logic noErrMode;
  logic shortStream;
  logic otherCmd;

  // Returns the masked write value of a register
  function automatic logic [7:0] masked(input logic [7:0] value, input logic [7:0] mask);
    masked = value & mask;
  endfunction : masked

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  assign access = psel & penable & pready;
  assign wrEn = access & pwrite;
  assign mapped = (paddr == rmtdc_pkg::RX_MODE_ADDR) | (paddr == rmtdc_pkg::DRV_CTL_ADDR)
                | (paddr == rmtdc_pkg::TX_MOD_ADDR);

  // Read mux, unmapped reads zero
  always_comb begin
    case (paddr)
      rmtdc_pkg::RX_MODE_ADDR: rdByte = rxMode;
      rmtdc_pkg::DRV_CTL_ADDR: rdByte = drvCtl;
      rmtdc_pkg::TX_MOD_ADDR: rdByte = txMod;
      default: rdByte = 8'h00;
    endcase
  end

  // One wait state: ready rises on the second access cycle
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pready <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
    end
  end

  // Read data and error presented together with ready
  // Outside the ready cycle the bus sees zero, so no stale byte lingers
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel & penable & ~pready) begin
      prdata <= {24'h00_0000, rdByte};
      pslverr <= ~mapped;
    end else begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // Receive mode register
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rxMode <= rmtdc_pkg::RX_MODE_RESET;
    end else if (wrEn && paddr == rmtdc_pkg::RX_MODE_ADDR) begin
      rxMode <= masked(pwdata[7:0], rmtdc_pkg::RX_MODE_MASK);
    end
  end

  // Driver control register, bit 2 held at zero
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      drvCtl <= rmtdc_pkg::DRV_CTL_RESET; // RL18
    end else if (wrEn && paddr == rmtdc_pkg::DRV_CTL_ADDR) begin
      drvCtl <= masked(pwdata[7:0], rmtdc_pkg::DRV_CTL_MASK); // RL20
    end
  end

  // Modulation register, only the full depth bit is kept
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      txMod <= rmtdc_pkg::TX_MOD_RESET;
    end else if (wrEn && paddr == rmtdc_pkg::TX_MOD_ADDR) begin
      txMod <= masked(pwdata[7:0], rmtdc_pkg::TX_MOD_MASK); // RL20
    end
  end

  // ----------------------------------------------------------------
  // Mode outputs
  // ----------------------------------------------------------------
  // Reserved speed and framing codes are stored and passed on as written
  assign crcCheckEnable = rxMode[rmtdc_pkg::RX_CRC_EN_BIT]; // RL1
  assign rxRate = rxMode[rmtdc_pkg::RX_SPEED_LSB +: 3]; // RL3
  assign receive_frame_format = rxMode[rmtdc_pkg::RX_FRAME_LSB +: 2]; // RL9
  assign fullDepthAsk = txMod[rmtdc_pkg::FORCE_FULL_BIT]; // RL17

  // Preset comes from the mode settings whenever RF traffic runs
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      crcPresetFromMode <= 1'b0;
    end else begin
      crcPresetFromMode <= rfComm; // RL19
    end
  end

  // ----------------------------------------------------------------
  // Receiver sequencing
  // ----------------------------------------------------------------
  assign multiMode = rxMode[rmtdc_pkg::RX_MULTI_BIT];
  assign noErrMode = rxMode[rmtdc_pkg::RX_NOERR_BIT];
  assign shortStream = rxBitCount < rmtdc_pkg::MIN_STREAM_BITS;
  assign otherCmd = cmdWrite & (cmdCode != rmtdc_pkg::CMD_RECEIVE_CODE);

  // Receiver activity; a new start wins over any stop in the same cycle
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rxActive <= 1'b0;
    end else if (rxStart) begin
      rxActive <= 1'b1;
    end else if (otherCmd) begin
      rxActive <= 1'b0; // RL7
    end else if (rxActive && rxStreamEnd && !multiMode && !(shortStream && noErrMode)) begin
      // Any valid stream end closes single-frame reception; ignored short streams do not
      rxActive <= 1'b0; // RL5 RL4
    end
  end

  // Error byte append after each stream in multiple mode, except ignored short streams
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      fifoWrite <= 1'b0;
      fifoData <= 8'h00;
    end else if (rxActive && rxStreamEnd && multiMode && !(shortStream && noErrMode)) begin
      fifoWrite <= 1'b1; // RL8
      fifoData <= errorFlags; // RL8
    end else begin
      fifoWrite <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Driver stage
  // ----------------------------------------------------------------
  rmtdc_driver uDriver (
    .clock(clock),
    .rst_n(rst_n),
    .carrierIn(carrierIn),
    .txModulate(txModulate),
    .drvCtl(drvCtl),
    .forceFull(txMod[rmtdc_pkg::FORCE_FULL_BIT]),
    .antennaDriverA(antennaDriverA),
    .antennaDriverB(antennaDriverB),
    .reducedDepth(reducedDepth)
  );

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  // Reset check keeps running while reset is low
  a_drv_reset_val: assert property (disable iff (1'b0) // RL18
    !rst_n |=> drvCtl == 8'h80)
    else $error("driver control reset value wrong");
  a_crc_enable_wr: assert property ( // RL1
    wrEn && paddr == rmtdc_pkg::RX_MODE_ADDR |=> crcCheckEnable == $past(pwdata[7]))
    else $error("CRC enable not taken from write");
  a_rate_field_wr: assert property ( // RL3
    wrEn && paddr == rmtdc_pkg::RX_MODE_ADDR |=> rxRate == $past(pwdata[6:4]))
    else $error("receive rate not taken from write");
  a_frame_field_wr: assert property ( // RL9
    wrEn && paddr == rmtdc_pkg::RX_MODE_ADDR |=> receive_frame_format == $past(pwdata[1:0]))
    else $error("framing not taken from write");
  a_short_keeps_rx: assert property ( // RL4
    rxActive && rxStreamEnd && shortStream && noErrMode && !otherCmd
    |=> rxActive && !fifoWrite)
    else $error("short stream ended reception");
  a_single_stops_rx: assert property ( // RL5
    rxActive && rxStreamEnd && !multiMode && !shortStream && !rxStart |=> !rxActive)
    else $error("single frame mode did not stop");
  a_multi_stays_rx: assert property ( // RL7
    rxActive && multiMode && !otherCmd |=> rxActive)
    else $error("multiple mode stopped by itself");
  a_cmd_stops_rx: assert property (otherCmd && !rxStart |=> !rxActive) // RL7
    else $error("other command did not end reception");
  a_err_byte_add: assert property ( // RL8
    rxActive && rxStreamEnd && multiMode && !shortStream
    |=> fifoWrite && fifoData == $past(errorFlags) ##1 !fifoWrite)
    else $error("error byte not appended once");
  a_reserved_zero: assert property (drvCtl[2] == 1'b0 && txMod[7] == 1'b0 // RL20
    && txMod[5:0] == 6'h00)
    else $error("reserved bit set");
  a_preset_auto: assert property (rfComm |=> crcPresetFromMode) // RL19
    else $error("mode preset not selected during RF traffic");
  a_ready_wait: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("ready not a single pulse");

  // Register access checks
  a_unmapped_err: assert property ( // RL20
    access && !mapped |-> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  a_mapped_no_err: assert property (access && mapped |-> !pslverr) // RL20
    else $error("error reply on mapped register");
  a_ctl_read_back: assert property ( // RL20
    access && !pwrite && paddr == rmtdc_pkg::DRV_CTL_ADDR |-> prdata == {24'h00_0000, drvCtl})
    else $error("driver control read data wrong");
  a_ctl_write_mask: assert property ( // RL20
    wrEn && paddr == rmtdc_pkg::DRV_CTL_ADDR |=> drvCtl == ($past(pwdata[7:0]) & 8'hFB))
    else $error("driver control write not masked");
  a_mod_write_mask: assert property ( // RL20
    wrEn && paddr == rmtdc_pkg::TX_MOD_ADDR |=> txMod == ($past(pwdata[7:0]) & 8'h40))
    else $error("modulation write not masked");

  // Receiver and driver checks
  a_fifo_quiet: assert property (!rxActive || !multiMode |=> !fifoWrite) // RL8
    else $error("error byte appended outside multiple reception");
  a_drv_b_idle: assert property ( // RL12
    !drvCtl[rmtdc_pkg::DRV_B_EN_BIT]
    |=> antennaDriverB == $past(drvCtl[rmtdc_pkg::DRV_B_INV_OFF_BIT]))
    else $error("disabled driver B level wrong");
  a_drv_a_mod: assert property ( // RL16 RL11
    drvCtl[rmtdc_pkg::DRV_A_EN_BIT] && !txModulate
    |=> antennaDriverA == ($past(carrierIn) ^ $past(drvCtl[rmtdc_pkg::DRV_A_INV_ON_BIT])))
    else $error("enabled driver A not carrying carrier");

  // Scenario covers
  c_multi_append: cover property (rxActive && multiMode ##1 fifoWrite);
  c_short_ignored: cover property (rxActive && rxStreamEnd && shortStream && noErrMode);
  c_drv_write: cover property (wrEn && paddr == rmtdc_pkg::DRV_CTL_ADDR);
  c_cmd_stop: cover property (rxActive && otherCmd);
  c_unmapped_read: cover property (access && !mapped && !pwrite);

endmodule : rmtdc_top
